// ### core/ascp_top.sv
`include "ascp_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module ascp_top #(
	parameter bit GAIN_VARIANT = 1'b1,
	parameter int RESULT_BITS  = 16
) (
	input  wire logic              clk_i,
	input  wire logic              reset_i,
	input  wire logic              sclk_i,
	input  wire logic              cs_n_i,
	input  wire logic              din_i,
	output logic                   dout_o,
	output logic                   dout_oe_n_o,
	input  wire ascp_pkg::ascp_conv_t conv_i,
	output logic                   conv_start_o,
	output logic                   cal_start_o,
	output logic [1:0]             cal_type_o,
	output logic                   power_down_o,
	output logic [2:0]             rate_code_o,
	output logic [10:0]            rate_sps_x10_o,
	output ascp_pkg::ascp_cfg_t    cfg_o,
	output logic [2:0]             gain_code_o,
	output logic [3:0]             cal_disable_o,
	input  wire logic [3:0]        gpio_i,
	output logic [3:0]             gpio_o,
	output logic [3:0]             gpio_oe_n_o
);
	import ascp_pkg::*;

	localparam logic [23:0] RES_MASK = 24'hFFFFFF << (24 - RESULT_BITS);

	// ---- serial clock domain ----
	ascp_phase_t phase_q;
	logic [4:0]  cnt_q;
	logic [23:0] sh_q;
	logic [7:0]  cmd_q;
	logic        ev_pend_q;
	ascp_evt_t   ev_q;
	logic [23:0] out_sh_q;
	logic        shifting_q;
	logic [7:0]  cmd_next;
	logic [4:0]  data_len;
	logic        cmd_is_read;

	// ---- system clock domain ----
	logic        cs_s1_q, cs_s2_q;
	logic        ev_s1_q, ev_s2_q, ev_s3_q;
	logic        ev_fire;
	logic [3:0]  gpio_s1_q, gpio_s2_q;
	logic [7:0]  config_q, gpio_q, gaincal_q;
	logic [23:0] result_q;
	logic [23:0] cal_q [`ASCP_CAL_COUNT];
	logic [23:0] snap_q [`ASCP_REG_COUNT];
	logic        rdy_q, ovr_q, und_q, busy_q, calor_q;
	logic [2:0]  rate_q;
	logic        busy_pin_q;
	logic [7:0]  ev_byte;

	// a register is 24 bits wide from the result upward
	function automatic logic [4:0] len_of(input logic [3:0] sel);
		if (sel >= `ASCP_SEL_RESULT) begin
			return `ASCP_WIDE_BITS;
		end
		return `ASCP_NARROW_BITS;
	endfunction

	function automatic logic [10:0] sps_x10(input logic [2:0] code);
		case (code)
			3'h0: return 11'd10;
			3'h1: return 11'd25;
			3'h2: return 11'd50;
			3'h3: return 11'd100;
			3'h4: return 11'd150;
			3'h5: return 11'd300;
			3'h6: return 11'd600;
			default: return 11'd1200;
		endcase
	endfunction

	// read-back value of one register, narrow ones left aligned for msb-first shifting
	function automatic logic [23:0] word_of(input logic [3:0] sel);
		logic [7:0] gp;
		gp = {gpio_q[7:4], (gpio_q[3:0] & gpio_q[7:4]) | (gpio_s2_q & ~gpio_q[7:4])};
		if (sel == `ASCP_SEL_STATUS) begin
			return {calor_q, rate_q, ovr_q, und_q, busy_q, rdy_q, 16'h0000};
		end else if (sel == `ASCP_SEL_CONFIG) begin
			return {config_q, 16'h0000};
		end else if (sel == `ASCP_SEL_GPIO) begin
			return {gp, 16'h0000};
		end else if (sel == `ASCP_SEL_GAINCAL) begin
			return {gaincal_q, 16'h0000};
		end else if (sel == `ASCP_SEL_RESULT) begin
			return result_q;
		end else if (sel <= `ASCP_SEL_LAST) begin
			return cal_q[2'(sel - `ASCP_SEL_CAL_BASE)];
		end
		return 24'h000000;
	endfunction

	assign cmd_next    = {sh_q[6:0], din_i};
	assign data_len    = len_of(cmd_q[4:1]);
	assign cmd_is_read = cmd_q[`ASCP_CMD_START] & cmd_q[`ASCP_CMD_MODE] & ~cmd_q[`ASCP_CMD_RSV]
		& (cmd_q[`ASCP_CMD_RW] == `ASCP_CMD_READ);

	// frame sequencer; chip select high holds it cleared so clock edges do nothing
	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			phase_q   <= PH_CMD;
			cnt_q     <= 5'd0;
		end else begin
			case (phase_q)
				PH_CMD: begin
					cnt_q <= cnt_q + 5'd1;
					if (cnt_q == `ASCP_CMD_BITS - 5'd1) begin
						cnt_q <= 5'd0;
						if (!cmd_next[`ASCP_CMD_START]) begin
							phase_q <= PH_DONE; // no start marker: frame ignored
						end else if (cmd_next[`ASCP_CMD_MODE] && cmd_next[`ASCP_CMD_RSV]) begin
							phase_q <= PH_DONE;
						end else if (!cmd_next[`ASCP_CMD_MODE] || cmd_next[`ASCP_CMD_RW] == `ASCP_CMD_READ) begin
							phase_q   <= PH_DONE;
						end else begin
							phase_q <= PH_DATA;
						end
					end
				end
				PH_DATA: begin
					cnt_q <= cnt_q + 5'd1;
					if (cnt_q == data_len - 5'd1) begin
						phase_q   <= PH_DONE;
					end
				end
				default: begin
					phase_q <= PH_DONE;
				end
			endcase
		end
	end

	// shift in on rising edges, msb first; event word held until the next frame
	always_ff @(posedge sclk_i) begin
		if (!cs_n_i) begin
			sh_q <= {sh_q[22:0], din_i};
		end
		if (!cs_n_i && phase_q == PH_CMD && cnt_q == `ASCP_CMD_BITS - 5'd1) begin
			cmd_q        <= cmd_next;
			ev_q.sel     <= cmd_next[4:1];
			ev_q.data    <= {16'h0000, cmd_next};
			ev_q.kind    <= !cmd_next[`ASCP_CMD_MODE] ? EV_CMD : EV_READ;
		end else if (!cs_n_i && phase_q == PH_DATA && cnt_q == data_len - 5'd1) begin
			ev_q.kind <= EV_WRITE;
			ev_q.data <= {sh_q[22:0], din_i};
		end
	end

	// frame-done flag outlives chip select, else short frames never reach clk_i; next frame drops it
	always_ff @(posedge sclk_i or posedge reset_i) begin
		if (reset_i) begin
			ev_pend_q <= 1'b0;
		end else if (!cs_n_i && phase_q == PH_CMD && cnt_q == `ASCP_CMD_BITS - 5'd1) begin
			ev_pend_q <= cmd_next[`ASCP_CMD_START] & (~cmd_next[`ASCP_CMD_MODE]
				| (~cmd_next[`ASCP_CMD_RSV] & (cmd_next[`ASCP_CMD_RW] == `ASCP_CMD_READ)));
		end else if (!cs_n_i && phase_q == PH_DATA && cnt_q == data_len - 5'd1) begin
			ev_pend_q <= 1'b1;
		end else if (!cs_n_i && phase_q == PH_CMD && cnt_q == 5'd0) begin
			ev_pend_q <= 1'b0;
		end
	end

	// read data leaves on falling edges, first bit right after the command byte
	always_ff @(negedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			out_sh_q   <= 24'h000000;
			shifting_q <= 1'b0;
		end else if (phase_q == PH_DONE && cmd_is_read && !shifting_q) begin
			out_sh_q   <= (cmd_q[4:1] <= `ASCP_SEL_LAST) ? snap_q[cmd_q[4:1]] : 24'h000000;
			shifting_q <= 1'b1;
		end else begin
			out_sh_q <= {out_sh_q[22:0], 1'b0};
		end
	end

	// status level between transfers, data bit while shifting
	assign dout_o      = shifting_q ? out_sh_q[23] : busy_pin_q;
	assign dout_oe_n_o = cs_n_i;

	// synchronisers for chip select, frame event and gpio pins
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			cs_s1_q   <= 1'b1;
			cs_s2_q   <= 1'b1;
			ev_s1_q   <= 1'b0;
			ev_s2_q   <= 1'b0;
			ev_s3_q   <= 1'b0;
			gpio_s1_q <= 4'h0;
			gpio_s2_q <= 4'h0;
		end else begin
			cs_s1_q   <= cs_n_i;
			cs_s2_q   <= cs_s1_q;
			ev_s1_q   <= ev_pend_q;
			ev_s2_q   <= ev_s1_q;
			ev_s3_q   <= ev_s2_q;
			gpio_s1_q <= gpio_i;
			gpio_s2_q <= gpio_s1_q;
		end
	end

	// ev_q was settled at least two clocks before the rising edge is seen
	assign ev_fire = ev_s2_q & ~ev_s3_q;
	assign ev_byte = ev_q.data[7:0];

	// snapshot frozen while a frame runs, so the serial side reads stable words
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			for (int i = 0; i < `ASCP_REG_COUNT; i++) begin
				snap_q[i] <= `ASCP_RST_WIDE;
			end
		end else if (cs_s2_q) begin
			for (int i = 0; i < `ASCP_REG_COUNT; i++) begin
				snap_q[i] <= word_of(4'(i));
			end
		end
	end

	// register writes from the serial side
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			config_q  <= `ASCP_RST_CONFIG;
			gpio_q    <= `ASCP_RST_GPIO;
			gaincal_q <= `ASCP_RST_GAINCAL;
			for (int i = 0; i < `ASCP_CAL_COUNT; i++) begin
				cal_q[i] <= `ASCP_RST_WIDE;
			end
		end else if (ev_fire && ev_q.kind == EV_WRITE) begin
			if (ev_q.sel == `ASCP_SEL_CONFIG) begin
				config_q <= ev_byte;
			end else if (ev_q.sel == `ASCP_SEL_GPIO) begin
				gpio_q <= ev_byte;
			end else if (ev_q.sel == `ASCP_SEL_GAINCAL) begin
				gaincal_q <= ev_byte;
			end else if (ev_q.sel >= `ASCP_SEL_CAL_BASE && ev_q.sel <= `ASCP_SEL_LAST) begin
				cal_q[2'(ev_q.sel - `ASCP_SEL_CAL_BASE)] <= ev_q.data;
			end
			// status and result selects fall through untouched
		end
	end

	// command-mode decode into converter requests
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			conv_start_o <= 1'b0;
			cal_start_o  <= 1'b0;
			cal_type_o   <= 2'b00;
			power_down_o <= 1'b0;
			rate_q       <= 3'h0;
		end else begin
			conv_start_o <= 1'b0;
			cal_start_o  <= 1'b0;
			if (ev_fire && ev_q.kind == EV_CMD) begin
				if (ev_byte[5:4] != 2'b00) begin
					// calibration only with power-down and rate clear
					if (ev_byte[3:0] == 4'h0) begin
						cal_start_o  <= 1'b1;
						cal_type_o   <= ev_byte[5:4];
						power_down_o <= 1'b0;
					end
				end else if (ev_byte[3]) begin
					power_down_o <= 1'b1;
				end else begin
					conv_start_o <= 1'b1;
					power_down_o <= 1'b0;
					rate_q       <= ev_byte[2:0];
				end
			end
		end
	end

	// status flags; a new result beats a read that clears it in the same cycle
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rdy_q    <= 1'b0;
			ovr_q    <= 1'b0;
			und_q    <= 1'b0;
			busy_q   <= 1'b0;
			calor_q  <= 1'b0;
			result_q <= `ASCP_RST_WIDE;
		end else begin
			busy_q  <= conv_i.busy;
			calor_q <= conv_i.cal_overrange;
			if (conv_i.valid) begin
				rdy_q <= 1'b1;
				ovr_q <= conv_i.overrange;
				und_q <= conv_i.underrange;
				// msb flip turns two's complement into offset binary
				result_q <= (conv_i.result ^ {config_q[`ASCP_CFG_FORMAT], 23'h000000}) & RES_MASK;
			end else if (ev_fire && ev_q.kind == EV_READ && ev_q.sel == `ASCP_SEL_RESULT) begin
				rdy_q <= 1'b0;
			end
		end
	end

	// registered copies of the busy pin level and of the rate, config, gain and gpio outputs
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			busy_pin_q     <= 1'b1;
			rate_code_o    <= 3'h0;
			rate_sps_x10_o <= 11'd10;
			cfg_o          <= '0;
			gain_code_o    <= 3'h0;
			cal_disable_o  <= 4'hF;
			gpio_o         <= 4'h0;
			gpio_oe_n_o    <= 4'hF;
		end else begin
			busy_pin_q     <= ~rdy_q;
			rate_code_o    <= rate_q;
			rate_sps_x10_o <= sps_x10(rate_q);
			cfg_o.mains_freq_select       <= config_q[`ASCP_CFG_MAINS];
			cfg_o.polarity_select         <= config_q[`ASCP_CFG_POL];
			cfg_o.external_clock_select   <= config_q[`ASCP_CFG_EXTERNAL_CLOCK_SELECT];
			cfg_o.reference_buffer_enable <= config_q[`ASCP_CFG_REFERENCE_BUFFER_ENABLE];
			cfg_o.input_buffer_enable     <= config_q[`ASCP_CFG_INPUT_BUFFER_ENABLE];
			cfg_o.offset_binary           <= config_q[`ASCP_CFG_FORMAT];
			cfg_o.single_shot_mode        <= config_q[`ASCP_CFG_SSHOT];
			// fixed-gain build never applies a gain
			gain_code_o   <= GAIN_VARIANT ? gaincal_q[7:5] : 3'h0;
			cal_disable_o <= gaincal_q[4:1];
			gpio_o        <= gpio_q[3:0];
			gpio_oe_n_o   <= ~gpio_q[7:4];
		end
	end

endmodule

`default_nettype wire

// ### core/ascp_consts.svh
`ifndef ASCP_CONSTS_SVH
`define ASCP_CONSTS_SVH

// register select codes carried in the command byte
`define ASCP_SEL_STATUS   4'h0
`define ASCP_SEL_CONFIG   4'h1
`define ASCP_SEL_GPIO     4'h2
`define ASCP_SEL_GAINCAL  4'h3
`define ASCP_SEL_RESULT   4'h4
`define ASCP_SEL_CAL_BASE 4'h5
`define ASCP_SEL_LAST     4'h8
`define ASCP_REG_COUNT    9
`define ASCP_CAL_COUNT    4

// reset values
`define ASCP_RST_CONFIG   8'h02
`define ASCP_RST_GPIO     8'h0F
`define ASCP_RST_GAINCAL  8'h1E
`define ASCP_RST_WIDE     24'h000000

// command byte fields
`define ASCP_CMD_START    7
`define ASCP_CMD_MODE     6
`define ASCP_CMD_RSV      5
`define ASCP_CMD_RW       0
`define ASCP_CMD_READ     1'b1

// converter_config fields
`define ASCP_CFG_MAINS    7
`define ASCP_CFG_POL      6
`define ASCP_CFG_EXTERNAL_CLOCK_SELECT   5
`define ASCP_CFG_REFERENCE_BUFFER_ENABLE   4
`define ASCP_CFG_INPUT_BUFFER_ENABLE   3
`define ASCP_CFG_FORMAT   2
`define ASCP_CFG_SSHOT    1

// frame lengths in serial clocks
`define ASCP_CMD_BITS     5'd8
`define ASCP_NARROW_BITS  5'd8
`define ASCP_WIDE_BITS    5'd24

`endif

// ### core/ascp_pkg.sv
`include "ascp_consts.svh"

package ascp_pkg;

	// serial frame phase, gray along cmd -> data -> done
	typedef enum logic [1:0] {
		PH_CMD  = 2'b00,
		PH_DATA = 2'b01,
		PH_DONE = 2'b11
	} ascp_phase_t;

	typedef enum logic [1:0] {
		EV_CMD   = 2'b00,
		EV_WRITE = 2'b01,
		EV_READ  = 2'b11
	} ascp_evkind_t;

	// one finished frame handed to the system clock side
	typedef struct packed {
		ascp_evkind_t kind;
		logic [3:0]   sel;
		logic [23:0]  data;
	} ascp_evt_t;

	// live converter settings
	typedef struct packed {
		logic mains_freq_select;
		logic polarity_select;
		logic external_clock_select;
		logic reference_buffer_enable;
		logic input_buffer_enable;
		logic offset_binary;
		logic single_shot_mode;
	} ascp_cfg_t;

	// what the converter core reports
	typedef struct packed {
		logic [23:0] result;
		logic        valid;
		logic        overrange;
		logic        underrange;
		logic        busy;
		logic        cal_overrange;
	} ascp_conv_t;

endpackage

// ### test/ascp_host.sv
`timescale 1ns/100ps
`default_nettype none
module ascp_host (
	output logic		sclk_o,
	output logic		cs_n_o,
	output logic		din_o,
	input wire logic	dout_i
);
	// serial clock stands still low between frames
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		din_o = 1'b0;
	end

	// one whole frame: command byte, then n data bits
	task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd, input int n,
		output logic [23:0] rd, output logic idle);
		logic [31:0] sh;
		sh = {cmd, wd};
		rd = 24'h0;
		cs_n_o = 1'b0;
		#160;
		idle = dout_i;
		for (int i = 0; i < 8 + n; i++) begin
			din_o = sh[31];
			sh = sh << 1;
			#15 sclk_o = 1'b1;
			if (i >= 8)
				rd = {rd[22:0], dout_i};
			#15 sclk_o = 1'b0;
		end
		cs_n_o = 1'b1;
		din_o = ~din_o; // released line, no stale level
		#320; // gap lets the frame land in clk domain
	endtask
endmodule
`default_nettype wire

// ### test/ascp_top_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module ascp_chk #(
	parameter bit GAIN_VARIANT = 1'b1,
	parameter int RESULT_BITS  = 16
) (
	input wire logic		clk_i,
	input wire logic		reset_i,
	input wire logic		cs_n_i,
	input wire logic		dout_oe_n_o,
	input wire logic		conv_start_o,
	input wire logic		cal_start_o,
	input wire logic [1:0]		cal_type_o,
	input wire logic		power_down_o,
	input wire logic [2:0]		rate_code_o,
	input wire logic [10:0]		rate_sps_x10_o,
	input wire ascp_pkg::ascp_cfg_t	cfg_o,
	input wire logic [3:0]		gpio_o,
	input wire logic [3:0]		gpio_oe_n_o
);
	import ascp_pkg::*;
	logic [3:0]	idle_q;
	logic [10:0]	sps_tab [8];
	assign sps_tab = '{11'h00A, 11'h019, 11'h032, 11'h064, 11'h096, 11'h12C, 11'h258, 11'h4B0};

	// cycles since chip select went high, saturating
	always_ff @(posedge clk_i) begin
		if (reset_i || !cs_n_i)
			idle_q <= 4'h0;
		else if (idle_q != 4'hF)
			idle_q <= idle_q + 4'h1;
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);

	a_conv_pulse: assert property (conv_start_o |=> !conv_start_o)
		else $error("conversion start wider than one cycle");
	a_cal_pulse: assert property (cal_start_o |=> !cal_start_o)
		else $error("calibration start wider than one cycle");
	a_oe_cs: assert property (dout_oe_n_o == cs_n_i)
		else $error("serial output enable not following chip select");
	a_cal_code: assert property (cal_start_o |-> ##1 cal_type_o != 2'h0)
		else $error("calibration started with empty type");
	a_pd_clear: assert property ((conv_start_o || cal_start_o) |-> ##2 !power_down_o)
		else $error("power-down kept after a start");
	a_pd_noconv: assert property ($rose(power_down_o) |-> !conv_start_o && !cal_start_o)
		else $error("power-down came with a start");
	a_rate_table: assert property ($stable(rate_code_o)[*2] |-> rate_sps_x10_o == sps_tab[rate_code_o])
		else $error("sample rate does not match rate code");
	a_idle_hold: assert property (idle_q > 4'h6 |-> $stable(gpio_o) && $stable(gpio_oe_n_o) && $stable(cfg_o))
		else $error("settings changed with chip select high");
endmodule

bind ascp_top ascp_chk #(.GAIN_VARIANT(GAIN_VARIANT), .RESULT_BITS(RESULT_BITS)) i_chk (.clk_i(clk_i),
	.reset_i(reset_i), .cs_n_i(cs_n_i), .dout_oe_n_o(dout_oe_n_o), .conv_start_o(conv_start_o),
	.cal_start_o(cal_start_o), .cal_type_o(cal_type_o), .power_down_o(power_down_o),
	.rate_code_o(rate_code_o), .rate_sps_x10_o(rate_sps_x10_o), .cfg_o(cfg_o), .gpio_o(gpio_o),
	.gpio_oe_n_o(gpio_oe_n_o));
`default_nettype wire

// ### test/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import ascp_pkg::*;
	logic		clk_i, reset_i, sclk, cs_n, din, dout, dout_oe_n;
	logic		conv_start, cal_start, power_down;
	logic [1:0]	cal_type;
	logic [2:0]	rate_code, gain_code;
	logic [10:0]	rate_sps;
	logic [3:0]	cal_dis, gpio_in, gpio_out, gpio_oe_n;
	ascp_conv_t	conv;
	ascp_cfg_t	cfg;
	wire		dout_w;
	int		err_total = 0, n_tests = 0, n_conv = 0, n_cal = 0;

	// pin seen by the host: floats while deselected
	assign dout_w = dout_oe_n ? 1'bz : dout;

	ascp_top i_dut (.clk_i(clk_i), .reset_i(reset_i), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
		.dout_o(dout), .dout_oe_n_o(dout_oe_n), .conv_i(conv), .conv_start_o(conv_start),
		.cal_start_o(cal_start), .cal_type_o(cal_type), .power_down_o(power_down),
		.rate_code_o(rate_code), .rate_sps_x10_o(rate_sps), .cfg_o(cfg), .gain_code_o(gain_code),
		.cal_disable_o(cal_dis), .gpio_i(gpio_in), .gpio_o(gpio_out), .gpio_oe_n_o(gpio_oe_n));
	ascp_host i_host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout_w));

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	// start pulses are single cycles, so count them
	always @(posedge clk_i) begin
		n_conv <= n_conv + int'(conv_start);
		n_cal <= n_cal + int'(cal_start);
	end

	task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// register access; narrow write data rides in the top byte, narrow read data comes back in the low byte
	task automatic rd_reg(input logic [3:0] s, output logic [23:0] v);
		logic idle;
		i_host.xfer({3'b110, s, 1'b1}, 24'h0, s < 4'h4 ? 8 : 24, v, idle);
	endtask
	task automatic wr_reg(input logic [3:0] s, input logic [23:0] v);
		logic [23:0] r;
		logic idle;
		i_host.xfer({3'b110, s, 1'b0}, s < 4'h4 ? {v[7:0], 16'h0} : v, s < 4'h4 ? 8 : 24, r, idle);
	endtask

	task automatic t_reset_regs();
		logic [23:0] v;
		logic idle;
		logic [7:0] exp [4] = '{8'h00, 8'h02, 8'h06, 8'h1E};
		for (int s = 0; s < 4; s++) begin
			rd_reg(4'(s), v);
			chk("reset reg", v, {16'h0, exp[s]});
		end
		chk("config out", {17'h0, cfg}, 24'h000001);
		// reserved bit set in a register write: whole frame ignored
		i_host.xfer(8'hE2, 24'hFF0000, 8, v, idle);
		chk("reserved bit", {17'h0, cfg}, 24'h000001);
	endtask

	task automatic t_writes();
		logic [23:0] v;
		wr_reg(4'h2, 24'h0000F1);
		chk("gpio pins", {16'h0, gpio_oe_n, gpio_out}, 24'h000001);
		rd_reg(4'h2, v);
		chk("gpio read", v, 24'h0000F1);
		wr_reg(4'h3, 24'h0000E0);
		chk("gain", {17'h0, gain_code, cal_dis}, 24'h000070);
		wr_reg(4'h0, 24'h0000FF);
		rd_reg(4'h0, v);
		chk("status write", v, 24'h000000);
		for (int s = 5; s < 10; s++)
			wr_reg(4'(s), 24'hA5C300 + 24'(s));
		for (int s = 5; s < 10; s++) begin
			rd_reg(4'(s), v);
			chk("wide reg", v, s < 9 ? 24'hA5C300 + 24'(s) : 24'h0);
		end
	endtask

	task automatic t_rates();
		logic [23:0] v;
		logic idle;
		logic [10:0] sps [8] = '{11'h00A, 11'h019, 11'h032, 11'h064, 11'h096, 11'h12C, 11'h258, 11'h4B0};
		int c0;
		c0 = n_conv;
		for (int r = 0; r < 8; r++) begin
			i_host.xfer({5'b10000, 3'(r)}, 24'h0, 0, v, idle);
			chk("rate code", {21'h0, rate_code}, 24'(r));
			chk("rate sps", {13'h0, rate_sps}, {13'h0, sps[r]});
		end
		// no start marker: neither a conversion nor a new rate
		i_host.xfer(8'h03, 24'h0, 0, v, idle);
		chk("no start bit", {21'h0, rate_code}, 24'h000007);
		chk("conv starts", 24'(n_conv - c0), 24'h000008);
		rd_reg(4'h0, v);
		chk("status rate", v, 24'h000070);
		c0 = n_cal;
		for (int k = 1; k < 4; k++) begin
			i_host.xfer({2'b10, 2'(k), 4'h0}, 24'h0, 0, v, idle);
			chk("cal type", {22'h0, cal_type}, 24'(k));
		end
		chk("cal starts", 24'(n_cal - c0), 24'h000003);
		c0 = n_conv;
		i_host.xfer(8'h88, 24'h0, 0, v, idle);
		chk("power down", {23'h0, power_down}, 24'(n_conv - c0) + 24'h1);
	endtask

	// converter hands over a result; read status, then the result
	task automatic t_result(input logic [28:0] c, input logic [23:0] st, input logic [23:0] res);
		logic [23:0] v;
		logic idle;
		@(posedge clk_i);
		conv <= c;
		@(posedge clk_i);
		conv.valid <= 1'b0;
		repeat (4) @(posedge clk_i);
		i_host.xfer(8'hC1, 24'h0, 8, v, idle);
		chk("status", v, st);
		chk("idle level", {23'h0, idle}, 24'h0);
		rd_reg(4'h4, v);
		chk("result", v, res);
		i_host.xfer(8'hC1, 24'h0, 8, v, idle);
		chk("ready clear", {22'h0, v[0], idle}, 24'h000001);
	endtask

	// output format switched to offset binary for the next result
	task automatic t_format();
		wr_reg(4'h1, 24'h000006);
		chk("format", {17'h0, cfg}, 24'h000003);
	endtask

	task automatic finish_test();
		if (err_total == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		reset_i = 1'b1;
		conv = '0;
		gpio_in = 4'h6;
		repeat (5) @(posedge clk_i);
		reset_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		t_reset_regs();
		t_writes();
		t_rates();
		t_result({24'h123456, 5'b11001}, 24'h0000F9, 24'h123400);
		t_format();
		t_result({24'hF0F0F0, 5'b10110}, 24'h000077, 24'h70F000);
		finish_test();
	end

	// hang guard, well past the longest run
	initial begin
		#300000;
		err_total++;
		finish_test();
	end
endmodule
`default_nettype wire
